// ===== src/caf_filter_ctl.sv
`timescale 1ns/1ps

// What this block does
// - Bit 15 enables filter 29 when one and disables it when zero.
// - Bits 14-13 pick acceptance mask 0 to 3 for filter 29 by their binary value.
// - Bits 12-8 name the receive FIFO, 0 to 31, that gets messages matching filter 29 but not filter 28.
// - Bit 7 enables filter 28 when one and disables it when zero.
// - Bits 6-5 pick acceptance mask 0 to 3 for filter 28 by their binary value.
// - Bits 4-0 name the receive FIFO that gets messages matching filter 28, 0 meaning FIFO 0.
// - Mask and FIFO selectors of a filter change only while its enable bit is zero.
module caf_filter_ctl
    import caf_pkg::*;
#(
    parameter int IDW   = ID_W,
    parameter int NMASK = NUM_MASKS
) (
    input  wire logic              mclk,
    input  wire logic              rst_n,
    input  wire logic              ce,
    input  wire logic [ADDR_W-1:0] avs_address,
    input  wire logic              avs_read,
    input  wire logic              avs_write,
    input  wire logic [DATA_W-1:0] avs_writedata,
    input  wire logic [BE_W-1:0]   avs_byteenable,
    output logic [DATA_W-1:0]      avs_readdata,
    output logic                   avs_waitrequest,
    input  caf_rx_msg_t            rx_msg,
    output caf_store_t             store
);

    // Registers
    caf_filt_ctl_t                 ctl_28;
    caf_filt_ctl_t                 ctl_29;
    logic [NMASK-1:0][IDW-1:0]     masks;
    logic [IDW-1:0]                id_28;
    logic [IDW-1:0]                id_29;
    logic                          stat_valid;
    logic                          stat_filter_29;
    logic [FIFO_SEL_W-1:0]         stat_fifo;
    logic                          ack;
    logic [DATA_W-1:0]             rdata;
    caf_store_t                    store_q;

    caf_filt_ctl_t                 next_ctl_28;
    caf_filt_ctl_t                 next_ctl_29;
    logic [NMASK-1:0][IDW-1:0]     next_masks;
    logic [IDW-1:0]                next_id_28;
    logic [IDW-1:0]                next_id_29;
    logic                          next_stat_valid;
    logic                          next_stat_filter_29;
    logic [FIFO_SEL_W-1:0]         next_stat_fifo;
    logic                          next_ack;
    logic [DATA_W-1:0]             next_rdata;
    caf_store_t                    next_store;

    logic                          req;
    logic                          wr_en;
    logic                          rd_en;
    logic                          hit_28;
    logic                          hit_29;
    caf_store_t                    routed;

    // Merge write data into an old word under the byte enables
    function automatic logic [DATA_W-1:0] merge_word(
        input logic [DATA_W-1:0] old_w,
        input logic [DATA_W-1:0] new_w,
        input logic [BE_W-1:0]   be
    );
        logic [DATA_W-1:0] res;
        res = old_w;
        for (int b = 0; b < BE_W; b++) begin
            if (be[b]) begin
                res[b*8 +: 8] = new_w[b*8 +: 8];
            end
        end
        return res;
    endfunction

    // Widen an identifier-sized field to a bus word
    function automatic logic [DATA_W-1:0] widen_id(input logic [IDW-1:0] v);
        logic [DATA_W-1:0] res;
        res = ZERO_WORD;
        res[IDW-1:0] = v;
        return res;
    endfunction

    // Apply one filter's byte, holding selectors while the filter is on
    function automatic caf_filt_ctl_t write_ctl(
        input caf_filt_ctl_t cur,
        input logic [CTL_W-1:0] wbyte
    );
        caf_filt_ctl_t res;
        caf_filt_ctl_t w;
        w = caf_filt_ctl_t'(wbyte);
        res = cur;
        res.enable = w.enable;
        if (!cur.enable) begin
            res.mask_select = w.mask_select;
            res.fifo_select = w.fifo_select;
        end
        return res;
    endfunction

    // One wait cycle per access: read data is ready when waitrequest drops
    assign req             = avs_read || avs_write;
    assign avs_waitrequest = req && !ack;
    assign wr_en           = ce && avs_write && ack;
    assign rd_en           = ce && avs_read && !ack;
    assign avs_readdata    = rdata;
    assign store           = store_q;

    // Filter units
    caf_match #(
        .IDW         (IDW),
        .NMASK       (NMASK)
    ) u_match_28 (
        .en          (ctl_28.enable),
        .mask_select (ctl_28.mask_select),
        .masks       (masks),
        .filter_id   (id_28),
        .rx          (rx_msg),
        .hit         (hit_28)
    );

    caf_match #(
        .IDW         (IDW),
        .NMASK       (NMASK)
    ) u_match_29 (
        .en          (ctl_29.enable),
        .mask_select (ctl_29.mask_select),
        .masks       (masks),
        .filter_id   (id_29),
        .rx          (rx_msg),
        .hit         (hit_29)
    );

    caf_route u_route (
        .hit_28 (hit_28),
        .hit_29 (hit_29),
        .ctl_28 (ctl_28),
        .ctl_29 (ctl_29),
        .rx     (rx_msg),
        .store  (routed)
    );

    // Bus handshake next state
    always_comb begin
        next_ack = ack;
        if (ce) begin
            next_ack = req && !ack;
        end
    end

    // Register writes
    always_comb begin
        logic [DATA_W-1:0] ctl_word;
        logic [DATA_W-1:0] merged;
        ctl_word    = {16'h0, ctl_29, ctl_28};
        merged      = ZERO_WORD;
        next_ctl_28 = ctl_28;
        next_ctl_29 = ctl_29;
        next_masks  = masks;
        next_id_28  = id_28;
        next_id_29  = id_29;
        if (wr_en) begin
            case (avs_address)
                OFS_FILTER_CTL: begin
                    merged = merge_word(ctl_word, avs_writedata, avs_byteenable);
                    if (avs_byteenable[F28_BYTE]) begin
                        next_ctl_28 = write_ctl(ctl_28, merged[F28_LSB +: CTL_W]);
                    end
                    if (avs_byteenable[F29_BYTE]) begin
                        next_ctl_29 = write_ctl(ctl_29, merged[F29_LSB +: CTL_W]);
                    end
                end
                OFS_MASK_0: begin
                    merged = merge_word(widen_id(masks[0]), avs_writedata, avs_byteenable);
                    next_masks[0] = merged[IDW-1:0];
                end
                OFS_MASK_1: begin
                    merged = merge_word(widen_id(masks[1]), avs_writedata, avs_byteenable);
                    next_masks[1] = merged[IDW-1:0];
                end
                OFS_MASK_2: begin
                    merged = merge_word(widen_id(masks[2]), avs_writedata, avs_byteenable);
                    next_masks[2] = merged[IDW-1:0];
                end
                OFS_MASK_3: begin
                    merged = merge_word(widen_id(masks[3]), avs_writedata, avs_byteenable);
                    next_masks[3] = merged[IDW-1:0];
                end
                OFS_FILTER28_ID: begin
                    merged = merge_word(widen_id(id_28), avs_writedata, avs_byteenable);
                    next_id_28 = merged[IDW-1:0];
                end
                OFS_FILTER29_ID: begin
                    merged = merge_word(widen_id(id_29), avs_writedata, avs_byteenable);
                    next_id_29 = merged[IDW-1:0];
                end
                default: begin
                    merged = ZERO_WORD;
                end
            endcase
        end
    end

    // Read data, captured in the wait cycle; unmapped reads give zero
    always_comb begin
        next_rdata = rdata;
        if (rd_en) begin
            case (avs_address)
                OFS_FILTER_CTL:   next_rdata = {16'h0, ctl_29, ctl_28};
                OFS_MASK_0:       next_rdata = widen_id(masks[0]);
                OFS_MASK_1:       next_rdata = widen_id(masks[1]);
                OFS_MASK_2:       next_rdata = widen_id(masks[2]);
                OFS_MASK_3:       next_rdata = widen_id(masks[3]);
                OFS_FILTER28_ID:  next_rdata = widen_id(id_28);
                OFS_FILTER29_ID:  next_rdata = widen_id(id_29);
                OFS_MATCH_STATUS: begin
                    next_rdata = ZERO_WORD;
                    next_rdata[STAT_VALID_BIT] = stat_valid;
                    next_rdata[STAT_FILTER_BIT] = stat_filter_29;
                    next_rdata[STAT_FIFO_LSB +: FIFO_SEL_W] = stat_fifo;
                end
                default:          next_rdata = ZERO_WORD;
            endcase
        end
    end

    // Store output and last-match status; status keeps the latest hit
    always_comb begin
        next_store          = store_q;
        next_stat_valid     = stat_valid;
        next_stat_filter_29 = stat_filter_29;
        next_stat_fifo      = stat_fifo;
        if (ce) begin
            next_store = routed;
            if (routed.valid) begin
                next_stat_valid     = 1'b1;
                next_stat_filter_29 = routed.filter_29;
                next_stat_fifo      = routed.fifo;
            end
        end
    end

    // All state, frozen while the clock enable is low
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ack            <= 1'b0;
            rdata          <= ZERO_WORD;
            ctl_28         <= RST_CTL;
            ctl_29         <= RST_CTL;
            masks          <= {NMASK{RST_MASK}};
            id_28          <= RST_ID;
            id_29          <= RST_ID;
            store_q        <= '0;
            stat_valid     <= 1'b0;
            stat_filter_29 <= 1'b0;
            stat_fifo      <= '0;
        end else begin
            ack            <= next_ack;
            rdata          <= next_rdata;
            ctl_28         <= next_ctl_28;
            ctl_29         <= next_ctl_29;
            masks          <= next_masks;
            id_28          <= next_id_28;
            id_29          <= next_id_29;
            store_q        <= next_store;
            stat_valid     <= next_stat_valid;
            stat_filter_29 <= next_stat_filter_29;
            stat_fifo      <= next_stat_fifo;
        end
    end

endmodule

// ===== src/caf_match.sv
`timescale 1ns/1ps

// One acceptance filter: compares an identifier under the selected mask
module caf_match
    import caf_pkg::*;
#(
    parameter int IDW   = ID_W,
    parameter int NMASK = NUM_MASKS
) (
    input  wire logic                       en,
    input  wire logic [MASK_SEL_W-1:0]      mask_select,
    input  wire logic [NMASK-1:0][IDW-1:0]  masks,
    input  wire logic [IDW-1:0]             filter_id,
    input  caf_rx_msg_t                     rx,
    output logic                            hit
);

    logic [IDW-1:0] sel_mask;

    // Mask picked by the two-bit selector, binary value is the mask number
    always_comb begin
        sel_mask = masks[mask_select];
    end

    // Masked compare; a disabled filter never hits
    always_comb begin
        hit = en && rx.valid && (((rx.id ^ filter_id) & sel_mask) == '0);
    end

endmodule

// ===== src/caf_pkg.sv
package caf_pkg;

    // Bus geometry
    localparam int DATA_W     = 32;
    localparam int ADDR_W     = 6;
    localparam int BE_W       = DATA_W / 8;

    // Filter geometry
    localparam int ID_W       = 29;
    localparam int NUM_MASKS  = 4;
    localparam int MASK_SEL_W = 2;
    localparam int FIFO_SEL_W = 5;
    localparam int CTL_W      = 8;

    // Byte addresses of the registers
    localparam logic [ADDR_W-1:0] OFS_FILTER_CTL   = 6'h00;
    localparam logic [ADDR_W-1:0] OFS_MASK_0       = 6'h04;
    localparam logic [ADDR_W-1:0] OFS_MASK_1       = 6'h08;
    localparam logic [ADDR_W-1:0] OFS_MASK_2       = 6'h0c;
    localparam logic [ADDR_W-1:0] OFS_MASK_3       = 6'h10;
    localparam logic [ADDR_W-1:0] OFS_FILTER28_ID  = 6'h14;
    localparam logic [ADDR_W-1:0] OFS_FILTER29_ID  = 6'h18;
    localparam logic [ADDR_W-1:0] OFS_MATCH_STATUS = 6'h1c;

    // Field positions inside the filter control register
    localparam int F28_LSB        = 0;
    localparam int F29_LSB        = 8;
    localparam int F28_BYTE       = 0;
    localparam int F29_BYTE       = 1;

    // Match status layout
    localparam int STAT_VALID_BIT  = 31;
    localparam int STAT_FILTER_BIT = 30;
    localparam int STAT_FIFO_LSB   = 0;

    // Reset values
    localparam logic [ID_W-1:0]   RST_ID     = 29'h0;
    localparam logic [ID_W-1:0]   RST_MASK   = 29'h0;
    localparam logic [DATA_W-1:0] ZERO_WORD  = 32'h0;

    // Per-filter control byte: enable, mask select, FIFO select
    typedef struct packed {
        logic                  enable;
        logic [MASK_SEL_W-1:0] mask_select;
        logic [FIFO_SEL_W-1:0] fifo_select;
    } caf_filt_ctl_t;

    localparam caf_filt_ctl_t RST_CTL = '{enable: 1'b0, mask_select: 2'h0, fifo_select: 5'h00};

    // Message offered by the receive path
    typedef struct packed {
        logic            valid;
        logic [ID_W-1:0] id;
    } caf_rx_msg_t;

    // Message handed to the FIFO write side
    typedef struct packed {
        logic                  valid;
        logic                  filter_29;
        logic [FIFO_SEL_W-1:0] fifo;
        logic [ID_W-1:0]       id;
    } caf_store_t;

endpackage

// ===== src/caf_route.sv
`timescale 1ns/1ps

// Chooses the winning filter and the FIFO that receives the message
module caf_route
    import caf_pkg::*;
(
    input  wire logic    hit_28,
    input  wire logic    hit_29,
    input  caf_filt_ctl_t ctl_28,
    input  caf_filt_ctl_t ctl_29,
    input  caf_rx_msg_t  rx,
    output caf_store_t   store
);

    // Lower filter number wins when both match, so routing is deterministic
    always_comb begin
        store.valid     = hit_28 || hit_29;
        store.filter_29 = !hit_28 && hit_29;
        store.id        = rx.id;
        if (hit_28) begin
            store.fifo = ctl_28.fifo_select;
        end else if (hit_29) begin
            store.fifo = ctl_29.fifo_select;
        end else begin
            store.fifo = '0;
        end
    end

endmodule

// ===== test/caf_filter_ctl_assertions.sv
`timescale 1ns/1ps

// Watches the bus handshake and the store output at the block's ports
module caf_filter_ctl_chk
    import caf_pkg::*;
(
    input  wire logic              mclk,
    input  wire logic              rst_n,
    input  wire logic              ce,
    input  wire logic [ADDR_W-1:0] avs_address,
    input  wire logic              avs_read,
    input  wire logic              avs_write,
    input  wire logic [DATA_W-1:0] avs_readdata,
    input  wire logic              avs_waitrequest,
    input  caf_rx_msg_t            rx_msg,
    input  caf_store_t             store
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    // Any pending request
    logic rq;
    assign rq = avs_read | avs_write;

    // Bus: one wait cycle, then answer; readdata holds after capture
    a_wait_answer: assert property ($rose(rq) && ce |=> !avs_waitrequest)
        else $error("waitrequest not released one cycle after request");
    a_wait_idle: assert property (!rq |-> !avs_waitrequest)
        else $error("waitrequest high with no request");
    a_read_hold: assert property (avs_read && !avs_waitrequest |=> $stable(avs_readdata))
        else $error("readdata moved right after capture");
    a_unmapped_zero: assert property (avs_read && !avs_waitrequest
        && avs_address > OFS_MATCH_STATUS |-> avs_readdata == '0)
        else $error("unmapped read not zero");
    a_ctl_upper_zero: assert property (avs_read && !avs_waitrequest
        && avs_address == OFS_FILTER_CTL |-> avs_readdata[31:16] == 16'h0000)
        else $error("control upper half not zero");

    // Store follows exactly one offered message, one cycle later
    a_store_cause: assert property (store.valid && $past(ce) |-> $past(rx_msg.valid))
        else $error("store without a message");
    a_store_id: assert property (store.valid && $past(ce) |-> store.id == $past(rx_msg.id))
        else $error("stored id differs from offered id");
    a_no_rx_quiet: assert property (ce && !rx_msg.valid |=> !store.valid)
        else $error("store valid without message");

    c_write: cover property (avs_write && !avs_waitrequest);
    c_hit_29: cover property (store.valid && store.filter_29);
    c_hit_28: cover property (store.valid && !store.filter_29);
endmodule

bind caf_filter_ctl caf_filter_ctl_chk i_caf_filter_ctl_chk (
    .mclk(mclk), .rst_n(rst_n), .ce(ce), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .rx_msg(rx_msg), .store(store));

// ===== test/caf_filter_ctl_tb_top.sv
`timescale 1ns/1ps

`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_errors++; \
    $display("[ERR] %s exp %h got %h", nm, e, g); end end

module caf_filter_ctl_tb_top
    import caf_pkg::*;
;
    logic              mclk = 1'b0;
    logic              rst_n = 1'b0;
    logic              ce = 1'b1;
    logic [ADDR_W-1:0] adr = '0;
    logic              rd = 1'b0;
    logic              wr = 1'b0;
    logic [DATA_W-1:0] wd = '0;
    logic [BE_W-1:0]   be = '0;
    logic [DATA_W-1:0] rdata;
    logic              wreq;
    caf_rx_msg_t       rx;
    caf_store_t        st;
    int                n_errors = 0;
    int                n_checks = 0;

    // 250 MHz
    always #2 mclk = ~mclk;

    caf_filter_ctl #(.IDW(ID_W), .NMASK(NUM_MASKS)) i_caf_filter_ctl (
        .mclk(mclk), .rst_n(rst_n), .ce(ce), .avs_address(adr), .avs_read(rd),
        .avs_write(wr), .avs_writedata(wd), .avs_byteenable(be), .avs_readdata(rdata),
        .avs_waitrequest(wreq), .rx_msg(rx), .store(st));
    caf_rx_model i_caf_rx_model (.mclk(mclk), .rx_msg(rx));

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // One bus access; request held until the edge that sees waitrequest low
    task automatic bus(input logic w, input logic [ADDR_W-1:0] a,
                       input logic [DATA_W-1:0] d, input logic [BE_W-1:0] b,
                       output logic [DATA_W-1:0] q);
        int n;
        @(posedge mclk);
        adr <= a;
        wd <= d;
        be <= b;
        wr <= w;
        rd <= ~w;
        for (n = 0; n < 50; n++) begin
            @(posedge mclk);
            if (!wreq) break;
        end
        if (n == 50) begin
            n_errors++;
            give_verdict();
        end
        q = rdata;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask

    task automatic wr32(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                        input logic [BE_W-1:0] b);
        logic [DATA_W-1:0] q;
        bus(1'b1, a, d, b, q);
    endtask

    task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
        logic [DATA_W-1:0] q;
        bus(1'b0, a, '0, 4'hf, q);
        `CHK("readdata", e, q)
    endtask

    // Offer a message, then judge the store output one cycle later
    task automatic msg_chk(input logic [ID_W-1:0] id, input logic v,
                           input logic [FIFO_SEL_W-1:0] f, input logic f29);
        i_caf_rx_model.send(id);
        @(negedge mclk);
        `CHK("store.valid", v, st.valid)
        if (v) begin
            `CHK("store.fifo", f, st.fifo)
            `CHK("store.filter_29", f29, st.filter_29)
            `CHK("store.id", id, st.id)
        end
    endtask

    task automatic t_reset();
        rd_chk(OFS_FILTER_CTL, 32'h0000_0000);
        rd_chk(6'h20, 32'h0000_0000);
        rd_chk(OFS_MATCH_STATUS, 32'h0000_0000);
        msg_chk(29'h0, 1'b0, 5'h00, 1'b0);
        $display("test reset done");
    endtask

    // Mask k compares only bit k, filter ids stay 0
    task automatic t_route();
        logic [FIFO_SEL_W-1:0] fs;
        logic [DATA_W-1:0]     w;
        for (int k = 0; k < 4; k++)
            wr32(OFS_MASK_0 + 6'(4 * k), 32'h1 << k, 4'hf);
        for (int f = 0; f < 2; f++) begin
            for (int s = 0; s < 4; s++) begin
                fs = (f == 1) ? 5'(31 - s) : 5'(7 * s);
                w = 32'({1'b1, 2'(s), fs}) << (8 * f);
                wr32(OFS_FILTER_CTL, 32'h0, 4'hf);
                wr32(OFS_FILTER_CTL, w, 4'hf);
                rd_chk(OFS_FILTER_CTL, w);
                msg_chk(29'h1 << s, 1'b0, fs, 1'(f));
                msg_chk(29'h1 << ((s + 1) % 4), 1'b1, fs, 1'(f));
            end
        end
        $display("test route done");
    endtask

    // Selectors frozen while enabled, even in the write that clears enable
    task automatic t_protect();
        wr32(OFS_FILTER_CTL, 32'h0, 4'hf);
        wr32(OFS_FILTER_CTL, 32'h0000_a3c5, 4'hf);
        wr32(OFS_FILTER_CTL, 32'h0000_ffff, 4'hf);
        rd_chk(OFS_FILTER_CTL, 32'h0000_a3c5);
        wr32(OFS_FILTER_CTL, 32'h0000_1f00, 4'h2);
        rd_chk(OFS_FILTER_CTL, 32'h0000_23c5);
        wr32(OFS_FILTER_CTL, 32'h0000_1f00, 4'h2);
        rd_chk(OFS_FILTER_CTL, 32'h0000_1fc5);
        msg_chk(29'h1, 1'b1, 5'h05, 1'b0);
        $display("test protect done");
    endtask

    // Filter ids, both-hit priority, match status, clock-enable freeze
    task automatic t_status();
        wr32(OFS_FILTER28_ID, 32'h0000_0004, 4'hf);
        msg_chk(29'h4, 1'b1, 5'h05, 1'b0);
        msg_chk(29'h0, 1'b0, 5'h00, 1'b0);
        wr32(OFS_FILTER_CTL, 32'h0000_9fc5, 4'hf);
        rd_chk(OFS_FILTER_CTL, 32'h0000_9fc5);
        msg_chk(29'h4, 1'b1, 5'h05, 1'b0);
        msg_chk(29'h1, 1'b0, 5'h00, 1'b0);
        msg_chk(29'h0, 1'b1, 5'h1f, 1'b1);
        rd_chk(OFS_MATCH_STATUS, 32'hc000_001f);
        @(posedge mclk);
        ce <= 1'b0;
        msg_chk(29'h4, 1'b0, 5'h00, 1'b0);
        @(posedge mclk);
        ce <= 1'b1;
        rd_chk(OFS_MATCH_STATUS, 32'hc000_001f);
        $display("test status done");
    endtask

    initial begin
        repeat (20) @(posedge mclk);
        rst_n <= 1'b1;
        t_reset();
        t_route();
        t_protect();
        t_status();
        give_verdict();
    end
endmodule

// ===== test/caf_rx_model.sv
`timescale 1ns/1ps

// Receive path stand-in: offers one message for one cycle per call
module caf_rx_model
    import caf_pkg::*;
(
    input  wire logic  mclk,
    output caf_rx_msg_t rx_msg
);
    initial rx_msg = '0;

    // Idle id is inverted so a stale id never passes for a live one
    task automatic send(input logic [ID_W-1:0] id);
        @(posedge mclk);
        rx_msg <= '{valid: 1'b1, id: id};
        @(posedge mclk);
        rx_msg <= '{valid: 1'b0, id: ~id};
    endtask
endmodule
